// file: hdl/lpw_pkg.sv
// Package for the low-power mode and wakeup controller
package lpw_pkg;
   localparam int LPW_NUM_CFG_LINES  = 16;
   localparam int LPW_NUM_FIXED      = 10;
   localparam int LPW_NUM_LINES      = LPW_NUM_CFG_LINES + LPW_NUM_FIXED;
   localparam int LPW_NUM_PINS       = 38;
   localparam int LPW_NUM_WKPINS     = 3;
   localparam int LPW_SEL_W          = 6;
   localparam int LPW_CLK_MHZ_X10    = 250;
   localparam int LPW_STOP_WAKE_NS   = 3500;
   localparam int LPW_STBY_WAKE_NS   = 60000;
   localparam int LPW_NS_PER_CLK     = 40;
   localparam int LPW_STOP_WAKE_CYC  = LPW_STOP_WAKE_NS / LPW_NS_PER_CLK;
   localparam int LPW_STBY_WAKE_CYC  = LPW_STBY_WAKE_NS / LPW_NS_PER_CLK;
   localparam int LPW_RST_HOLD_CYC   = 4;
   localparam int LPW_OPT_LOAD_CYC   = 8;
   localparam int LPW_CNT_W          = 12;
   localparam logic [1:0] LPW_EDGE_RISE = 2'h1;
   localparam logic [1:0] LPW_EDGE_FALL = 2'h2;

   typedef enum logic [2:0] {
      LPW_ST_POR,
      LPW_ST_OPTLOAD,
      LPW_ST_RUN,
      LPW_ST_STOP,
      LPW_ST_STOP_WAKE,
      LPW_ST_STBY,
      LPW_ST_STBY_WAKE,
      LPW_ST_CORE_RST
   } lpw_state_e;

   // Oscillator and domain controls that leave the block together
   typedef struct packed {
      logic pll_en;
      logic msi_en;
      logic hsi_en;
      logic hse_en;
      logic lsi_en;
      logic lse_en;
      logic core_reg_on;
      logic clocks_run;
   } lpw_clk_ctl_s;

   // Fixed-line wakeup sources
   typedef struct packed {
      logic volt_det;
      logic rtc_alarm_a;
      logic rtc_alarm_b;
      logic rtc_tamper;
      logic rtc_tstamp;
      logic rtc_wakeup;
      logic serial;
      logic lp_serial;
      logic lp_timer;
      logic comparator;
   } lpw_fixed_s;

   // Standby exit causes
   typedef struct packed {
      logic ext_reset;
      logic watchdog;
      logic wakeup_pin;
      logic rtc;
   } lpw_exit_s;
endpackage

// file: hdl/lpw_edge_line.sv
// One event line: edge select, mask, pending flag
`timescale 1ns/1ps
module lpw_edge_line
   import lpw_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       sys_rst_i,
   input  wire logic       line_i,
   input  wire logic [1:0] edge_sel_i,
   input  wire logic       unmask_i,
   input  wire logic       clear_i,
   output logic            pending_o
);
   logic line_reg;
   logic line_next;
   logic pend_reg;
   logic pend_next;
   logic hit;

   always_comb begin
      line_next = line_i;
      hit       = ((edge_sel_i & LPW_EDGE_RISE) != 2'h0 && line_i && !line_reg) ||
                  ((edge_sel_i & LPW_EDGE_FALL) != 2'h0 && !line_i && line_reg);
      // Set wins over a clear in the same cycle
      pend_next = (pend_reg && !clear_i) || (hit && unmask_i);
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         // Track the line during reset so a pin already high at release is no edge
         line_reg <= line_next;
         pend_reg <= 1'b0;
      end else begin
         line_reg <= line_next;
         pend_reg <= pend_next;
      end
   end

   assign pending_o = pend_reg;
endmodule

// file: hdl/lpw_ctrl.sv
// Low-power mode entry, exit and wakeup event line control
// What this block does
// (R1) In the clock-stopped state every clock, the PLL and the MSI, HSI and HSE oscillators are off while RAM and registers are kept.
// (R2) During the clock-stopped state a wakeup-capable peripheral may turn the high-speed internal oscillator on.
// (R3) Any pending event line wakes the clock-stopped state and the core resumes within 3.5 us.
// (R4) Each configurable line takes any pin, and fixed lines carry detector, comparator, serial and timer events.
// (R5) The core-powered-off state turns the core regulator off; only standby circuitry keeps state.
// (R6) In the core-powered-off state with the clock in use one low-speed oscillator keeps running.
// (R7) With the clock in use, reset, watchdog, wakeup pins and clock events end core-off within 60 us.
// (R8) Without the clock, only reset or a wakeup pin rising edge ends core-off within 60 us.
// (R9) Entering a low-power state never stops the clock, watchdog or their oscillators on its own.
// (R10) A deep-sleep request puts the device into the clock-stopped or core-powered-off state.
// (R11) Each line selects rising, falling or both edges, is masked alone, and records a pending flag.
// (R12) 38 pins share 16 configurable lines and 10 further lines are fixed to internal events.
// (R13) After power-on the supply threshold starts the option byte load that sets brownout detection.
// (R14) Leaving the core-powered-off state restarts the core through the reset sequence.
`timescale 1ns/1ps
module lpw_ctrl
   import lpw_pkg::*;
#(
   parameter int NUM_PINS      = LPW_NUM_PINS,
   parameter int STBY_WAKE_CYC = LPW_STBY_WAKE_CYC
)
(
   input  wire logic                               clock_i,
   input  wire logic                               sys_rst_i,
   input  wire logic                               supply_ok_i,
   input  wire logic                               opt_brownout_off_i,
   input  wire logic                               deep_sleep_req_i,
   input  wire logic                               standby_sel_i,
   input  wire logic                               rtc_in_use_i,
   input  wire logic                               use_lse_i,
   input  wire logic                               rtc_osc_keep_i,
   input  wire logic                               wdg_osc_keep_i,
   input  wire logic                               periph_hsi_req_i,
   input  wire logic [NUM_PINS-1:0]                pins_i,
   input  wire logic [LPW_NUM_CFG_LINES*LPW_SEL_W-1:0] pin_sel_i,
   input  wire lpw_fixed_s                         fixed_i,
   input  wire logic [LPW_NUM_LINES*2-1:0]         edge_sel_i,
   input  wire logic [LPW_NUM_LINES-1:0]           unmask_i,
   input  wire logic [LPW_NUM_LINES-1:0]           pend_clear_i,
   input  wire logic [LPW_NUM_WKPINS-1:0]          wakeup_pin_i,
   input  wire logic                               external_reset_pin_i,
   input  wire logic                               independent_watchdog_rst_i,
   output lpw_clk_ctl_s                            clk_ctl_o,
   output logic                                    core_rst_o,
   output logic                                    core_run_o,
   output logic                                    brownout_en_o,
   output logic [LPW_NUM_LINES-1:0]                pending_o,
   output lpw_exit_s                               exit_cause_o,
   output logic                                    in_stop_o,
   output logic                                    in_standby_o
);
   logic [LPW_NUM_LINES-1:0] line_src;
   logic [LPW_NUM_LINES-1:0] pend;
   logic [LPW_NUM_WKPINS-1:0] wk_reg;
   logic [LPW_NUM_WKPINS-1:0] wk_next;
   logic                     wk_rise;
   logic                     rtc_evt;

   // Pin routing to the configurable lines, fixed lines above them
   genvar gi;
   generate
      for (gi = 0; gi < LPW_NUM_LINES; gi++) begin : g_line
         if (gi < LPW_NUM_CFG_LINES) begin : g_cfg
            logic [LPW_SEL_W-1:0] sel;
            assign sel = pin_sel_i[gi*LPW_SEL_W +: LPW_SEL_W];
            assign line_src[gi] = (int'(sel) < NUM_PINS) ? pins_i[sel] : 1'b0; // R4 R12
         end else begin : g_fix
            assign line_src[gi] = fixed_i[gi-LPW_NUM_CFG_LINES]; // R4 R12
         end
         lpw_edge_line u_line (
            .clock_i    (clock_i),
            .sys_rst_i  (sys_rst_i),
            .line_i     (line_src[gi]),
            .edge_sel_i (edge_sel_i[gi*2 +: 2]),
            .unmask_i   (unmask_i[gi]),
            .clear_i    (pend_clear_i[gi]),
            .pending_o  (pend[gi])
         ); // R11
      end
   endgenerate

   assign rtc_evt = fixed_i.rtc_alarm_a | fixed_i.rtc_alarm_b | fixed_i.rtc_tamper |
                    fixed_i.rtc_tstamp | fixed_i.rtc_wakeup;

   lpw_state_e             state_reg;
   lpw_state_e             state_next;
   logic [LPW_CNT_W-1:0]   cnt_reg;
   logic [LPW_CNT_W-1:0]   cnt_next;
   lpw_clk_ctl_s           clk_reg;
   lpw_clk_ctl_s           clk_next;
   logic                   core_rst_reg;
   logic                   core_rst_next;
   logic                   bor_reg;
   logic                   bor_next;
   lpw_exit_s              cause_reg;
   lpw_exit_s              cause_next;
   logic                   rtc_mode_reg;
   logic                   rtc_mode_next;
   logic                   lse_sel_reg;
   logic                   lse_sel_next;

   always_comb begin
      wk_next = wakeup_pin_i;
      wk_rise = |(wakeup_pin_i & ~wk_reg);
   end

   always_comb begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      clk_next      = clk_reg;
      core_rst_next = core_rst_reg;
      bor_next      = bor_reg;
      cause_next    = cause_reg;
      rtc_mode_next = rtc_mode_reg;
      lse_sel_next  = lse_sel_reg;
      unique case (state_reg)
         LPW_ST_POR: begin
            core_rst_next = 1'b1;
            if (supply_ok_i) begin
               state_next = LPW_ST_OPTLOAD; // R13
               cnt_next   = LPW_CNT_W'(LPW_OPT_LOAD_CYC);
            end
         end
         LPW_ST_OPTLOAD: begin
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == 1) begin
               bor_next   = !opt_brownout_off_i; // R13
               state_next = LPW_ST_CORE_RST;
               cnt_next   = LPW_CNT_W'(LPW_RST_HOLD_CYC);
            end
         end
         LPW_ST_CORE_RST: begin
            core_rst_next = 1'b1;
            clk_next      = '{pll_en: 1'b1, msi_en: 1'b1, hsi_en: 1'b1, hse_en: 1'b1,
                              lsi_en: 1'b1, lse_en: 1'b1, core_reg_on: 1'b1, clocks_run: 1'b1};
            cnt_next      = cnt_reg - 1'b1;
            if (cnt_reg == 1) begin
               core_rst_next = 1'b0; // R14
               state_next    = LPW_ST_RUN;
            end
         end
         LPW_ST_RUN: begin
            if (deep_sleep_req_i) begin // R10
               rtc_mode_next = rtc_in_use_i;
               lse_sel_next  = use_lse_i;
               cause_next    = '0;
               if (standby_sel_i) begin
                  state_next    = LPW_ST_STBY;
                  core_rst_next = 1'b1; // R5
                  // Only the standby oscillators stay; clock and watchdog sources are never forced off
                  clk_next = '{pll_en: 1'b0, msi_en: 1'b0, hsi_en: 1'b0, hse_en: 1'b0,
                               lsi_en: (rtc_in_use_i && !use_lse_i) || wdg_osc_keep_i,
                               lse_en: (rtc_in_use_i && use_lse_i) || rtc_osc_keep_i,
                               core_reg_on: 1'b0, clocks_run: 1'b0}; // R5 R6 R8 R9
               end else begin
                  state_next = LPW_ST_STOP;
                  clk_next   = '{pll_en: 1'b0, msi_en: 1'b0, hsi_en: 1'b0, hse_en: 1'b0,
                                 lsi_en: wdg_osc_keep_i, lse_en: rtc_osc_keep_i,
                                 core_reg_on: 1'b1, clocks_run: 1'b0}; // R1 R9
               end
            end
         end
         LPW_ST_STOP: begin
            clk_next.hsi_en = periph_hsi_req_i; // R2
            if (|pend) begin // R3
               state_next = LPW_ST_STOP_WAKE;
               clk_next.msi_en = 1'b1;
               // The state change after the pending flag costs a cycle, so the count stops one short
               cnt_next   = LPW_CNT_W'(LPW_STOP_WAKE_CYC - 1);
            end
         end
         LPW_ST_STOP_WAKE: begin
            // Resume just inside the bound; oscillator start-up is modelled by the count
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == 1) begin
               clk_next   = '{pll_en: 1'b1, msi_en: 1'b1, hsi_en: 1'b1, hse_en: 1'b1,
                              lsi_en: 1'b1, lse_en: 1'b1, core_reg_on: 1'b1, clocks_run: 1'b1};
               state_next = LPW_ST_RUN; // R3
            end
         end
         LPW_ST_STBY: begin
            cause_next.ext_reset  = external_reset_pin_i;
            cause_next.wakeup_pin = wk_rise;
            cause_next.watchdog   = rtc_mode_reg && independent_watchdog_rst_i; // R7
            cause_next.rtc        = rtc_mode_reg && rtc_evt; // R7
            if (external_reset_pin_i || wk_rise ||
                (rtc_mode_reg && (independent_watchdog_rst_i || rtc_evt))) begin // R7 R8
               state_next = LPW_ST_STBY_WAKE;
               cnt_next   = LPW_CNT_W'(STBY_WAKE_CYC);
               clk_next.core_reg_on = 1'b1;
            end
         end
         LPW_ST_STBY_WAKE: begin
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == LPW_CNT_W'(LPW_RST_HOLD_CYC + 1)) begin
               state_next = LPW_ST_CORE_RST; // R14
               cnt_next   = LPW_CNT_W'(LPW_RST_HOLD_CYC);
            end
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_reg    <= LPW_ST_POR;
         cnt_reg      <= '0;
         clk_reg      <= '0;
         core_rst_reg <= 1'b1;
         bor_reg      <= 1'b1;
         cause_reg    <= '0;
         rtc_mode_reg <= 1'b0;
         lse_sel_reg  <= 1'b0;
         wk_reg       <= wk_next;
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         clk_reg      <= clk_next;
         core_rst_reg <= core_rst_next;
         bor_reg      <= bor_next;
         cause_reg    <= cause_next;
         rtc_mode_reg <= rtc_mode_next;
         lse_sel_reg  <= lse_sel_next;
         wk_reg       <= wk_next;
      end
   end

   logic run_reg;
   logic stop_reg;
   logic stby_reg;
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         run_reg  <= 1'b0;
         stop_reg <= 1'b0;
         stby_reg <= 1'b0;
      end else begin
         run_reg  <= (state_next == LPW_ST_RUN);
         stop_reg <= (state_next == LPW_ST_STOP);
         stby_reg <= (state_next == LPW_ST_STBY);
      end
   end

   assign clk_ctl_o     = clk_reg;
   assign core_rst_o    = core_rst_reg;
   assign core_run_o    = run_reg;
   assign brownout_en_o = bor_reg;
   assign pending_o     = pend;
   assign exit_cause_o  = cause_reg;
   assign in_stop_o     = stop_reg;
   assign in_standby_o  = stby_reg;

   // Checks
   stop_clocks_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      in_stop_o |-> !clk_ctl_o.pll_en && !clk_ctl_o.clocks_run && clk_ctl_o.core_reg_on) // R1
      else $error("clock-stopped state left a clock running");
   stop_hsi_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      in_stop_o && $past(in_stop_o) |-> clk_ctl_o.hsi_en == $past(periph_hsi_req_i)) // R2
      else $error("high-speed oscillator does not follow peripheral request");
   stop_wake_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      in_stop_o && |pend |-> ##[1:87] core_run_o) // R3
      else $error("no resume within 3.5 us");
   stby_reg_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      in_standby_o |-> !clk_ctl_o.core_reg_on && core_rst_o) // R5
      else $error("core regulator on in core-off state");
   stby_lowosc_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      in_standby_o && rtc_mode_reg |-> clk_ctl_o.lsi_en || clk_ctl_o.lse_en) // R6
      else $error("no low-speed oscillator with clock in use");
   stby_exit_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      in_standby_o && external_reset_pin_i |-> ##1 state_reg == LPW_ST_STBY_WAKE) // R7 R8
      else $error("reset pin did not end core-off state");
   stby_norc_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      in_standby_o && !rtc_mode_reg && rtc_evt && !external_reset_pin_i && !wk_rise
      |=> state_reg == LPW_ST_STBY) // R8
      else $error("clock event woke core-off without clock in use");
   stby_restart_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == LPW_ST_STBY_WAKE ##1 state_reg != LPW_ST_STBY_WAKE
      |-> state_reg == LPW_ST_CORE_RST && core_rst_o) // R14
      else $error("core-off exit skipped reset sequence");
   sleep_entry_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == LPW_ST_RUN && deep_sleep_req_i |=> in_stop_o || in_standby_o) // R10
      else $error("deep-sleep request not taken");
   keep_osc_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == LPW_ST_RUN && deep_sleep_req_i && wdg_osc_keep_i |=> ##1 clk_ctl_o.lsi_en) // R9
      else $error("watchdog oscillator stopped by entry");
   keep_rtc_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == LPW_ST_RUN && deep_sleep_req_i && rtc_osc_keep_i |=> clk_ctl_o.lse_en) // R9
      else $error("clock oscillator stopped by entry");
   stop_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      in_stop_o && !(|pend) |=> in_stop_o) // R3
      else $error("clock-stopped state left without a pending line");
   stby_osc_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      in_standby_o |-> !clk_ctl_o.pll_en && !clk_ctl_o.msi_en && !clk_ctl_o.hsi_en && !clk_ctl_o.hse_en) // R5 R6
      else $error("fast oscillator running in core-off state");
   stby_lse_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      in_standby_o && rtc_mode_reg |-> (lse_sel_reg ? clk_ctl_o.lse_en : clk_ctl_o.lsi_en)) // R6
      else $error("selected low-speed oscillator stopped in core-off state");
   bor_load_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == LPW_ST_OPTLOAD && cnt_reg == 1 |=> brownout_en_o == !$past(opt_brownout_off_i)) // R13
      else $error("brownout enable not taken from option load");

   stop_cycle_c: cover property (@(posedge clock_i) in_stop_o ##[1:100] core_run_o);
   stby_cycle_c: cover property (@(posedge clock_i) in_standby_o ##[1:1000] state_reg == LPW_ST_CORE_RST);
   pend_set_c:   cover property (@(posedge clock_i) $rose(pend[0]));
   stby_rtc_c:   cover property (@(posedge clock_i) in_standby_o && rtc_mode_reg ##1 state_reg == LPW_ST_STBY_WAKE);
   stop_hsi_c:   cover property (@(posedge clock_i) in_stop_o && clk_ctl_o.hsi_en);
endmodule

// file: dv/lpw_core_model.sv
// Core-side model that issues deep-sleep requests while the core runs
`timescale 1ns/1ps
module lpw_core_model
   import lpw_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic sys_rst_i,
   input  wire logic core_run_i,
   input  wire logic sleep_cmd_i,
   input  wire logic standby_cmd_i,
   output logic      deep_sleep_req_o,
   output logic      standby_sel_o
);
   // Only a running core executes the sleep instruction, so a command in reset or low power is dropped
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         deep_sleep_req_o <= 1'h0;
         standby_sel_o    <= 1'h0;
      end else begin
         deep_sleep_req_o <= sleep_cmd_i & core_run_i;
         // Mode select toggles between requests so a stale value is never trusted
         standby_sel_o    <= sleep_cmd_i ? standby_cmd_i : ~standby_sel_o;
      end
   end
endmodule

// file: dv/lpw_ctrl_tb.sv
// Self-checking bench for the low-power mode and wakeup controller
`timescale 1ns/1ps
module lpw_ctrl_tb;
   import lpw_pkg::*;
   localparam int NP  = LPW_NUM_PINS;
   localparam int SWC = 10;
   typedef struct packed {
      logic [4:0] line;
      logic [1:0] sel;
      logic       um;
      logic       v0;
      logic       v1;
      logic       exp;
   } lpw_row_s;
   logic                                   clock_i, sys_rst_i, supply_ok, opt_off, rtc_use, use_lse;
   logic                                   rtc_keep, wdg_keep, hsi_req, xrst, wdg_rst, sleep_cmd, stby_cmd;
   logic                                   dsr, ssel, core_rst, core_run, bo_en, in_stop, in_stby;
   logic [NP-1:0]                          pins;
   logic [LPW_NUM_CFG_LINES*LPW_SEL_W-1:0] pin_sel;
   lpw_fixed_s                             fixed;
   logic [LPW_NUM_LINES*2-1:0]             edge_sel;
   logic [LPW_NUM_LINES-1:0]               unmask, pclr, pend;
   logic [LPW_NUM_WKPINS-1:0]              wk;
   lpw_clk_ctl_s                           clk_ctl;
   lpw_exit_s                              cause;
   int                                     miscompares, compares;
   lpw_row_s rows [8] = '{
      '{5'h00, LPW_EDGE_RISE, 1'h1, 1'h0, 1'h1, 1'h1},
      '{5'h00, LPW_EDGE_RISE, 1'h1, 1'h1, 1'h0, 1'h0},
      '{5'h00, LPW_EDGE_FALL, 1'h1, 1'h1, 1'h0, 1'h1},
      '{5'h00, LPW_EDGE_FALL, 1'h1, 1'h0, 1'h1, 1'h0},
      '{5'h00, 2'h3, 1'h1, 1'h0, 1'h1, 1'h1},
      '{5'h00, 2'h3, 1'h1, 1'h1, 1'h0, 1'h1},
      '{5'h00, LPW_EDGE_RISE, 1'h0, 1'h0, 1'h1, 1'h0},
      '{5'h19, LPW_EDGE_RISE, 1'h1, 1'h0, 1'h1, 1'h1}};

   lpw_core_model core_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .core_run_i(core_run),
      .sleep_cmd_i(sleep_cmd), .standby_cmd_i(stby_cmd), .deep_sleep_req_o(dsr), .standby_sel_o(ssel));

   lpw_ctrl #(.NUM_PINS(NP), .STBY_WAKE_CYC(SWC)) dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .supply_ok_i(supply_ok), .opt_brownout_off_i(opt_off), .deep_sleep_req_i(dsr), .standby_sel_i(ssel),
      .rtc_in_use_i(rtc_use), .use_lse_i(use_lse), .rtc_osc_keep_i(rtc_keep), .wdg_osc_keep_i(wdg_keep),
      .periph_hsi_req_i(hsi_req), .pins_i(pins), .pin_sel_i(pin_sel), .fixed_i(fixed),
      .edge_sel_i(edge_sel), .unmask_i(unmask), .pend_clear_i(pclr), .wakeup_pin_i(wk),
      .external_reset_pin_i(xrst), .independent_watchdog_rst_i(wdg_rst), .clk_ctl_o(clk_ctl),
      .core_rst_o(core_rst), .core_run_o(core_run), .brownout_en_o(bo_en), .pending_o(pend),
      .exit_cause_o(cause), .in_stop_o(in_stop), .in_standby_o(in_stby));

   initial begin
      clock_i = 1'h0;
      forever #20 clock_i = ~clock_i;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic drive_line(input logic [4:0] ln, input logic v);
      if (ln == 5'h00) pins[NP-1] <= v;
      else fixed.volt_det <= v;
   endtask

   // Counts negedges until the core runs; also notes whether the core was held in reset meanwhile
   task automatic wait_run(input int lim, output int n, output logic rs);
      n = 0;
      rs = 1'h0;
      @(negedge clock_i);
      while (core_run !== 1'h1 && n < lim) begin
         if (core_rst === 1'h1) rs = 1'h1;
         @(negedge clock_i);
         n++;
      end
      chk("core_run", 1'h1, core_run);
   endtask

   task automatic enter(input logic stby, input logic rtc);
      tick(1);
      stby_cmd  <= stby;
      rtc_use   <= rtc;
      sleep_cmd <= 1'h1;
      tick(1);
      sleep_cmd <= 1'h0;
      tick(3);
      @(negedge clock_i);
      chk("mode", {stby, !stby}, {in_stby, in_stop});
   endtask

   task automatic boot(input logic off);
      int n;
      logic rs;
      sys_rst_i <= 1'h1;
      opt_off   <= off;
      supply_ok <= 1'h0;
      tick(2);
      sys_rst_i <= 1'h0;
      tick(3);
      @(negedge clock_i);
      chk("core_rst", 1'h1, core_rst);
      chk("core_run", 1'h0, core_run);
      chk("pending", '0, pend);
      chk("brownout_en", 1'h1, bo_en);
      tick(1);
      supply_ok <= 1'h1;
      wait_run(20, n, rs);
      chk("boot_len", 1'h1, n >= 9);
      chk("brownout_en", !off, bo_en);
   endtask

   task automatic wrap_up;
      if (miscompares == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      tick(20000);
      miscompares++;
      wrap_up();
   end

   initial begin
      int n;
      logic rs;
      miscompares = 0;
      compares = 0;
      {sys_rst_i, supply_ok, opt_off, rtc_use, use_lse, rtc_keep, wdg_keep} = 7'h01;
      {hsi_req, xrst, wdg_rst, sleep_cmd, stby_cmd} = 5'h00;
      pins = '0;
      pin_sel = '0;
      pin_sel[5:0] = 6'h25;
      fixed = '0;
      edge_sel = '0;
      {unmask, pclr, wk} = '0;
      boot(1'h0);
      foreach (rows[i]) begin
         tick(1);
         edge_sel[int'(rows[i].line)*2 +: 2] <= rows[i].sel;
         unmask[rows[i].line] <= rows[i].um;
         drive_line(rows[i].line, rows[i].v0);
         tick(4);
         pclr <= '1;
         tick(1);
         pclr <= '0;
         tick(3);
         drive_line(rows[i].line, rows[i].v1);
         tick(4);
         @(negedge clock_i);
         chk("pending", rows[i].exp, pend[rows[i].line]);
      end
      // Stale pending flags would end the clock-stopped state at once, so clear them first
      tick(1);
      pclr <= '1;
      unmask <= 26'h00_0001;
      edge_sel[1:0] <= LPW_EDGE_RISE;
      pins[NP-1] <= 1'h0;
      tick(1);
      pclr <= '0;
      enter(1'h0, 1'h0);
      // The watchdog keep is set, so its low-speed oscillator stays on
      chk("clk_ctl", 8'h08, clk_ctl & 8'hfd);
      tick(1);
      hsi_req <= 1'h1;
      tick(3);
      @(negedge clock_i);
      chk("hsi_en", 1'h1, clk_ctl.hsi_en);
      tick(1);
      hsi_req <= 1'h0;
      pins[NP-1] <= 1'h1;
      wait_run(LPW_STOP_WAKE_CYC + 8, n, rs);
      // Count starts half a cycle before the pin is sampled and stops half a cycle after the core runs
      chk("stop_wake_len", 1'h1, n <= LPW_STOP_WAKE_NS / LPW_NS_PER_CLK + 1);
      enter(1'h1, 1'h0);
      chk("clk_ctl", 8'h08, clk_ctl);
      tick(1);
      fixed.rtc_alarm_a <= 1'h1;
      tick(SWC + 10);
      @(negedge clock_i);
      chk("in_standby", 1'h1, in_stby);
      tick(1);
      fixed.rtc_alarm_a <= 1'h0;
      wk <= 3'h4;
      tick(1);
      wk <= 3'h0;
      wait_run(SWC + 12, n, rs);
      chk("core_rst_seen", 1'h1, rs);
      chk("exit_cause", 4'h2, cause);
      // Without any keep the internal low-speed oscillator must come from the clock in use alone
      tick(1);
      wdg_keep <= 1'h0;
      enter(1'h1, 1'h1);
      chk("clk_ctl", 8'h08, clk_ctl);
      tick(1);
      fixed.rtc_tstamp <= 1'h1;
      tick(1);
      fixed.rtc_tstamp <= 1'h0;
      wait_run(SWC + 12, n, rs);
      chk("exit_cause", 4'h1, cause);
      tick(1);
      {use_lse, rtc_keep, wdg_keep} <= 3'h7;
      for (int k = 0; k < 4; k++) begin
         enter(1'h1, 1'h1);
         chk("clk_ctl", 8'h0c, clk_ctl);
         tick(1);
         case (k)
            0: xrst <= 1'h1;
            1: wdg_rst <= 1'h1;
            2: fixed.rtc_alarm_b <= 1'h1;
            default: fixed.rtc_wakeup <= 1'h1;
         endcase
         tick(1);
         {xrst, wdg_rst, fixed.rtc_alarm_b, fixed.rtc_wakeup} <= 4'h0;
         wait_run(SWC + 12, n, rs);
         chk("exit_cause", (k == 0) ? 4'h8 : (k == 1) ? 4'h4 : 4'h1, cause);
      end
      // Second reset in mid-run with brownout detection disabled by the option byte
      tick(1);
      boot(1'h1);
      wrap_up();
   end
endmodule
